// >>> pkg/tmt_defines.vh
// Purpose: constants for the timer three control block
// Assumes: 8-bit special-function register bus
// Notes: definitions only
`ifndef TMT_DEFINES_VH
`define TMT_DEFINES_VH
`define TMT_ADDR_CONTROL 8'h91
`define TMT_ADDR_RELOAD_LO 8'h92
`define TMT_ADDR_RELOAD_HI 8'h93
`define TMT_ADDR_COUNT_LO 8'h94
`define TMT_ADDR_COUNT_HI 8'h95
`define TMT_CONTROL_RESET 8'h00
`define TMT_BIT_HIGH_FLAG 7
`define TMT_BIT_LOW_FLAG 6
`define TMT_BIT_LOW_IRQ_EN 5
`define TMT_BIT_CAPTURE_EN 4
`define TMT_BIT_SPLIT 3
`define TMT_BIT_RUN 2
`define TMT_BIT_ALT_CLOCK 0
`define TMT_CONTROL_WR_MASK 8'hfd
`define TMT_SYS_DIV 12
`define TMT_EXT_DIV 8
`define TMT_BYTE_ZERO 8'h00
`define TMT_BYTE_MAX 8'hff
`endif

// >>> rtl/tmt_tick_gen.v
// Purpose: timebase ticks for the timer: system clock / 12 and external clock / 8
// Assumes: ext_osc_in is asynchronous and much slower than clk_in
// Notes: ticks are one-cycle pulses in the clk_in domain
`timescale 1ns/1ps
`include "tmt_defines.vh"
module tmt_tick_gen #(
    parameter SYS_DIV = `TMT_SYS_DIV,
    parameter EXT_DIV = `TMT_EXT_DIV
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire ext_osc_in,
    output reg sys_tick_out,
    output reg ext_tick_out,
    output reg ext_fall_out
);
    reg [3:0] sys_count;
    reg [2:0] ext_count;
    reg [2:0] ext_sync;
    wire ext_rise;
    // only the second and third stages are compared; the first stage feeds nothing else
    assign ext_rise = ext_sync[1] & ~ext_sync[2];
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            sys_count <= 4'h0;
            ext_count <= 3'h0;
            ext_sync <= 3'h0;
            sys_tick_out <= 1'b0;
            ext_tick_out <= 1'b0;
            ext_fall_out <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_osc_in};
            sys_tick_out <= (sys_count == SYS_DIV - 1);
            if (sys_count == SYS_DIV - 1) begin
                sys_count <= 4'h0;
            end else begin
                sys_count <= sys_count + 4'h1;
            end
            ext_tick_out <= 1'b0;
            ext_fall_out <= 1'b0;
            if (ext_rise) begin
                ext_count <= ext_count + 3'h1;
                // one timebase tick per divided period, on the divided clock's rising edge
                ext_tick_out <= (ext_count == EXT_DIV / 2 - 1);
                // divided clock falls when the counter wraps from high back to low
                ext_fall_out <= (ext_count == EXT_DIV - 1);
            end
        end
    end
endmodule // tmt_tick_gen

// >>> rtl/tmt_timer_three.v
// Purpose: timer three with its control register, counter, reload and capture
// Assumes: synchronous sfr bus, one write or read strobe per cycle, timer irq enable from outside
// Notes: read data and interrupt request are registered
`timescale 1ns/1ps
`include "tmt_defines.vh"
module tmt_timer_three #(
    parameter WIDTH = 8
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire ext_osc_in,
    input wire timer_irq_enable_in,
    input wire upper_byte_fast_clock_select_in,
    input wire lower_byte_fast_clock_select_in,
    input wire [7:0] sfr_addr_in,
    input wire [WIDTH-1:0] sfr_wdata_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    output reg [WIDTH-1:0] sfr_rdata_out,
    output reg irq_out,
    output reg high_overflow_flag_out,
    output reg low_overflow_flag_out
);
    reg [WIDTH-1:0] timer_three_control;
    reg [WIDTH-1:0] count_lower_byte;
    reg [WIDTH-1:0] count_upper_byte;
    reg [WIDTH-1:0] reload_lower_byte;
    reg [WIDTH-1:0] reload_upper_byte;
    reg [WIDTH-1:0] next_control;
    reg [WIDTH-1:0] next_rdata;
    wire sys_tick;
    wire ext_tick;
    wire ext_fall;
    wire high_flag;
    wire low_flag;
    wire low_irq_en;
    wire capture_en;
    wire split;
    wire run;
    wire alt_clock;
    wire alt_tick;
    wire lo_tick;
    wire hi_tick;
    wire lo_step;
    wire hi_step;
    wire lo_wrap;
    wire hi_wrap;
    wire capture;
    wire wr_ctrl;
    wire wr_count_lo;
    wire wr_count_hi;
    wire wr_reload_lo;
    wire wr_reload_hi;
    reg next_irq;
    reg [WIDTH-1:0] next_count_lower;
    reg [WIDTH-1:0] next_count_upper;
    reg [WIDTH-1:0] next_reload_lower;
    reg [WIDTH-1:0] next_reload_upper;

    tmt_tick_gen u_ticks (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ext_osc_in(ext_osc_in),
        .sys_tick_out(sys_tick),
        .ext_tick_out(ext_tick),
        .ext_fall_out(ext_fall)
    );

    assign high_flag = timer_three_control[`TMT_BIT_HIGH_FLAG];
    assign low_flag = timer_three_control[`TMT_BIT_LOW_FLAG];
    assign low_irq_en = timer_three_control[`TMT_BIT_LOW_IRQ_EN];
    assign capture_en = timer_three_control[`TMT_BIT_CAPTURE_EN];
    assign split = timer_three_control[`TMT_BIT_SPLIT];
    assign run = timer_three_control[`TMT_BIT_RUN];
    assign alt_clock = timer_three_control[`TMT_BIT_ALT_CLOCK];
    assign alt_tick = alt_clock ? ext_tick : sys_tick;
    assign lo_tick = lower_byte_fast_clock_select_in ? 1'b1 : alt_tick;
    // in 16-bit mode both bytes share the lower byte's timebase
    assign hi_tick = split ? (upper_byte_fast_clock_select_in ? 1'b1 : alt_tick) : lo_tick;
    assign lo_step = lo_tick & (split | run);
    assign lo_wrap = lo_step & (count_lower_byte == `TMT_BYTE_MAX);
    assign hi_step = split ? (hi_tick & run) : lo_wrap;
    assign hi_wrap = hi_step & (count_upper_byte == `TMT_BYTE_MAX);
    // capture is meant for 16-bit mode; split mode ignores it
    assign capture = capture_en & ~split & ext_fall;
    assign wr_ctrl = sfr_wr_in & (sfr_addr_in == `TMT_ADDR_CONTROL);

    always @* begin
        next_control = timer_three_control;
        if (wr_ctrl) begin
            next_control = sfr_wdata_in & `TMT_CONTROL_WR_MASK;
        end
        // no hardware clear path exists; sets override a same-cycle software clear
        if (hi_wrap | capture) begin
            next_control[`TMT_BIT_HIGH_FLAG] = 1'b1;
        end
        if (lo_wrap) begin
            next_control[`TMT_BIT_LOW_FLAG] = 1'b1;
        end
    end

    always @* begin
        case (sfr_addr_in)
            `TMT_ADDR_CONTROL: next_rdata = timer_three_control;
            `TMT_ADDR_RELOAD_LO: next_rdata = reload_lower_byte;
            `TMT_ADDR_RELOAD_HI: next_rdata = reload_upper_byte;
            `TMT_ADDR_COUNT_LO: next_rdata = count_lower_byte;
            `TMT_ADDR_COUNT_HI: next_rdata = count_upper_byte;
            default: next_rdata = `TMT_BYTE_ZERO;
        endcase
    end

    // decoded write strobes, one per addressable byte
    assign wr_count_lo = sfr_wr_in & (sfr_addr_in == `TMT_ADDR_COUNT_LO);
    assign wr_count_hi = sfr_wr_in & (sfr_addr_in == `TMT_ADDR_COUNT_HI);
    assign wr_reload_lo = sfr_wr_in & (sfr_addr_in == `TMT_ADDR_RELOAD_LO);
    assign wr_reload_hi = sfr_wr_in & (sfr_addr_in == `TMT_ADDR_RELOAD_HI);

    // level request follows the high flag, and the low flag only while its irq enable bit is set, so it drops once software clears them
    always @* begin
        next_irq = next_control[`TMT_BIT_HIGH_FLAG];
        if (next_control[`TMT_BIT_LOW_IRQ_EN]) begin
            next_irq = next_irq | next_control[`TMT_BIT_LOW_FLAG];
        end
        next_irq = next_irq & timer_irq_enable_in;
    end

    // lower byte: split wrap reloads its own byte, 16-bit wrap reloads both
    // a software write wins over the count so a loaded value is never lost
    always @* begin
        next_count_lower = count_lower_byte;
        if (wr_count_lo) begin
            next_count_lower = sfr_wdata_in;
        end else if (lo_wrap && (split || hi_wrap)) begin
            next_count_lower = reload_lower_byte;
        end else if (lo_step) begin
            next_count_lower = count_lower_byte + 8'h01;
        end
    end

    always @* begin
        next_count_upper = count_upper_byte;
        if (wr_count_hi) begin
            next_count_upper = sfr_wdata_in;
        end else if (hi_wrap) begin
            next_count_upper = reload_upper_byte;
        end else if (hi_step) begin
            next_count_upper = count_upper_byte + 8'h01;
        end
    end

    // a capture wins over a reload write that falls in the same cycle
    always @* begin
        next_reload_lower = reload_lower_byte;
        next_reload_upper = reload_upper_byte;
        if (capture) begin
            next_reload_lower = count_lower_byte;
            next_reload_upper = count_upper_byte;
        end else begin
            if (wr_reload_lo) begin
                next_reload_lower = sfr_wdata_in;
            end
            if (wr_reload_hi) begin
                next_reload_upper = sfr_wdata_in;
            end
        end
    end

    // flag outputs are copies of the register bits, launched on the same edge
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            timer_three_control <= `TMT_CONTROL_RESET;
            high_overflow_flag_out <= 1'b0;
            low_overflow_flag_out <= 1'b0;
        end else begin
            timer_three_control <= next_control;
            high_overflow_flag_out <= next_control[`TMT_BIT_HIGH_FLAG];
            low_overflow_flag_out <= next_control[`TMT_BIT_LOW_FLAG];
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

    // read data stands until the next read strobe
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= `TMT_BYTE_ZERO;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_lower_byte <= `TMT_BYTE_ZERO;
            count_upper_byte <= `TMT_BYTE_ZERO;
        end else begin
            count_lower_byte <= next_count_lower;
            count_upper_byte <= next_count_upper;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            reload_lower_byte <= `TMT_BYTE_ZERO;
            reload_upper_byte <= `TMT_BYTE_ZERO;
        end else begin
            reload_lower_byte <= next_reload_lower;
            reload_upper_byte <= next_reload_upper;
        end
    end
endmodule // tmt_timer_three

// >>> verif/tmt_props.sv
// Purpose: port assertions for timer three
// Assumes: flags and irq registered, write effect next edge
// Notes: bound to tmt_timer_three below
`timescale 1ns/1ps
module tmt_props (
    input wire clk_in,
    input wire reset_n_in,
    input wire timer_irq_enable_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_rdata_out,
    input wire irq_out,
    input wire high_overflow_flag_out,
    input wire low_overflow_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    wire ctl_wr = sfr_wr_in && sfr_addr_in == 8'h91;
    sequence s_set_h; ctl_wr && sfr_wdata_in[7]; endsequence
    sequence s_set_l; ctl_wr && sfr_wdata_in[6]; endsequence
    sequence s_ctl_rd; sfr_rd_in && sfr_addr_in == 8'h91; endsequence
    property p_hold_h; high_overflow_flag_out && !ctl_wr |=> high_overflow_flag_out; endproperty
    a_hold_h: assert property (p_hold_h) else $error("high flag dropped");
    property p_hold_l; low_overflow_flag_out && !ctl_wr |=> low_overflow_flag_out; endproperty
    a_hold_l: assert property (p_hold_l) else $error("low flag dropped");
    property p_sw_h; s_set_h |=> high_overflow_flag_out; endproperty
    a_sw_h: assert property (p_sw_h) else $error("high flag write lost");
    property p_sw_l; s_set_l |=> low_overflow_flag_out; endproperty
    a_sw_l: assert property (p_sw_l) else $error("low flag write lost");
    property p_rd1; s_ctl_rd |=> !sfr_rdata_out[1]; endproperty
    a_rd1: assert property (p_rd1) else $error("unused bit read high");
    property p_irq; $past(timer_irq_enable_in) && high_overflow_flag_out |-> irq_out; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_no_en; !$past(timer_irq_enable_in) |-> !irq_out; endproperty
    a_no_en: assert property (p_no_en) else $error("irq without enable");
    property p_no_flag; !high_overflow_flag_out && !low_overflow_flag_out |-> !irq_out; endproperty
    a_no_flag: assert property (p_no_flag) else $error("irq without flag");
endmodule // tmt_props
bind tmt_timer_three tmt_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .timer_irq_enable_in(timer_irq_enable_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out),
    .high_overflow_flag_out(high_overflow_flag_out),
    .low_overflow_flag_out(low_overflow_flag_out));

// >>> verif/tmt_timer_three_tb.sv
// Purpose: self-checking bench for timer three
// Assumes: inputs driven 1 ns after the rising edge
// Notes: ext oscillator runs free on clock edges, rates checked as exact tick counts
`timescale 1ns/1ps
module tmt_timer_three_tb;
    reg clk_in = 0, reset_n_in = 0, ext = 0, ien = 1, lfast = 1, wr = 0, rd = 0, hfast = 0;
    reg [7:0] addr = 8'h00, wd = 8'h00, v;
    wire [7:0] rdata;
    wire irq, hf, lf;
    integer err_count = 0, num_checks = 0, i;
    tmt_timer_three u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ext_osc_in(ext),
        .timer_irq_enable_in(ien), .upper_byte_fast_clock_select_in(hfast),
        .lower_byte_fast_clock_select_in(lfast), .sfr_addr_in(addr), .sfr_wdata_in(wd),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .irq_out(irq),
        .high_overflow_flag_out(hf), .low_overflow_flag_out(lf));
    initial forever #5 clk_in = ~clk_in;
    // four-cycle oscillator, so its divide-by-8 period is exactly 32 clocks
    always begin
        repeat (2) @(posedge clk_in);
        #1 ext = ~ext;
    end
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task sfr(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            #1 addr = a;
            wd = d;
            wr = w;
            rd = !w;
            @(posedge clk_in);
            #1 wr = 0;
            rd = 0;
            @(posedge clk_in);
            #1 v = rdata;
        end
    endtask
    task wait_flag(input high);
        begin
            i = 0;
            while (i < 300 && (high ? hf : lf) !== 1'b1) begin
                @(posedge clk_in);
                #1 i = i + 1;
            end
            if (i == 300) begin
                chk(1'b0, 1'b1);
                end_sim;
            end
        end
    endtask
    task t_regs;
        begin
            sfr(0, 8'h91, 0);
            chk(v, 8'h00);
            sfr(1, 8'h91, 8'hff);
            sfr(0, 8'h91, 0);
            chk(v, 8'hfd);
            sfr(1, 8'h91, 8'h00);
            sfr(0, 8'h91, 0);
            chk(v, 8'h00);
            sfr(0, 8'h90, 0);
            chk(v, 8'h00);
        end
    endtask
    task t_wrap;
        begin
            sfr(1, 8'h92, 8'h34);
            sfr(1, 8'h93, 8'h12);
            sfr(1, 8'h94, 8'hfd);
            sfr(1, 8'h95, 8'hff);
            sfr(1, 8'h91, 8'h04);
            wait_flag(1);
            chk(irq, 1);
            chk(lf, 1);
            sfr(1, 8'h91, 8'h00);
            sfr(0, 8'h95, 0);
            chk(v, 8'h12);
        end
    endtask
    task t_irq_en;
        begin
            ien = 0;
            sfr(1, 8'h91, 8'h80);
            chk(hf, 1);
            chk(irq, 0);
            ien = 1;
            @(posedge clk_in);
            #1 chk(irq, 1);
            sfr(1, 8'h91, 8'h00);
            chk(irq, 0);
        end
    endtask
    task t_upper;
        begin
            hfast = 1;
            sfr(1, 8'h95, 8'h00);
            sfr(1, 8'h91, 8'h0c);
            repeat (17) @(posedge clk_in);
            sfr(1, 8'h91, 8'h00);
            hfast = 0;
            sfr(0, 8'h95, 0);
            chk(v, 8'h14);
        end
    endtask
    task t_capture;
        begin
            sfr(1, 8'h92, 8'h11);
            sfr(1, 8'h94, 8'h55);
            sfr(1, 8'h95, 8'h66);
            repeat (40) @(posedge clk_in);
            sfr(0, 8'h92, 0);
            chk(v, 8'h11);
            chk(hf, 0);
            sfr(1, 8'h91, 8'h10);
            wait_flag(1);
            chk(irq, 1);
            sfr(0, 8'h92, 0);
            chk(v, 8'h55);
            sfr(0, 8'h93, 0);
            chk(v, 8'h66);
            sfr(0, 8'h94, 0);
            chk(v, 8'h55);
            sfr(1, 8'h91, 8'h00);
        end
    endtask
    task t_reset;
        begin
            sfr(1, 8'h91, 8'hc4);
            reset_n_in = 0;
            repeat (2) @(posedge clk_in);
            #1 reset_n_in = 1;
            chk(hf, 0);
            chk(lf, 0);
            chk(irq, 0);
            chk(rdata, 8'h00);
            sfr(0, 8'h91, 0);
            chk(v, 8'h00);
            sfr(0, 8'h94, 0);
            chk(v, 8'h00);
        end
    endtask
    task t_split;
        begin
            sfr(1, 8'h94, 8'hfe);
            sfr(1, 8'h95, 8'hfe);
            sfr(1, 8'h91, 8'h08);
            wait_flag(0);
            chk(irq, 0);
            sfr(0, 8'h95, 0);
            chk(v, 8'hfe);
            sfr(1, 8'h91, 8'h28);
            wait_flag(0);
            chk(irq, 1);
            sfr(1, 8'h91, 8'h00);
        end
    endtask
    task t_rate(input [7:0] ctl, input integer n, input [7:0] lo, input [7:0] hi);
        begin
            lfast = 0;
            sfr(1, 8'h94, 8'h00);
            sfr(1, 8'h91, ctl);
            repeat (n) @(posedge clk_in);
            sfr(1, 8'h91, 8'h00);
            sfr(0, 8'h94, 0);
            chk(v >= lo && v <= hi, 1);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        #1 reset_n_in = 1;
        t_regs;
        t_irq_en;
        t_wrap;
        t_split;
        // run spans n + 3 edges: 120 edges give 10 ticks of /12, 320 edges 10 of ext/8
        t_rate(8'h04, 117, 8'h0a, 8'h0a);
        t_rate(8'h05, 317, 8'h0a, 8'h0a);
        t_upper;
        t_capture;
        t_reset;
        end_sim;
    end
endmodule // tmt_timer_three_tb
